// ### crf_core.sv
// CPU register file, status flags, fetch stage, data-space decode and Avalon access
//
// How it works
// - Thirty-two 8-bit registers, single-cycle access
// - Read two operands, compute, write back
// - Next instruction fetched during current execution
// - Registers 26..31 form three 16-bit pointers
// - Z pointer also addresses flash tables
// - Data addresses 0..31 reach working registers
// - I/O reachable directly and at 0x20..0x5F, except the flags, which data space reaches at 0x3F, not 0x5F
// - 0x60..0xFF only through data-space access
// - Flags selected by alu_flag_mask refreshed after every ALU operation
// - Flags never saved or restored on interrupts
// - Bit 7 clear blocks every interrupt
// - Taken interrupt clears bit 7; return/set/clear
// - Bit 6 copy bit for store/load
// - Bit 5 holds low-nibble carry
// - Bit 4 equals negative xor overflow
// - Bit 3 signals signed overflow
// - Bit 2 set on negative result
// - Bit 1 set on zero result
// - Bit 0 holds carry or borrow
// - Four 8/16-bit read and write port combinations
// - Lower vector wins among pending interrupts
// - Accept one-word or two-word instructions
`timescale 1ns/1ps
module crf_core #(
  parameter int NUM_IRQ = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Program memory fetch
  output logic [15:0] prog_addr,
  input wire logic [15:0] prog_data,
  input wire logic pc_load,
  input wire logic [15:0] pc_load_val,
  output logic [15:0] exec_word,
  output logic [15:0] exec_ext_word,
  output logic exec_valid,
  input wire logic instr_long,
  // ALU operation
  input wire logic alu_en,
  input wire crf_pkg::crf_alu_op_t alu_op,
  input wire logic [4:0] src_a_idx,
  input wire logic [4:0] src_b_idx,
  input wire logic use_imm,
  input wire logic [7:0] imm_data,
  input wire logic [4:0] dst_idx,
  input wire logic [5:0] alu_flag_mask,
  output logic [7:0] src_a_data,
  output logic [7:0] src_b_data,
  // 16-bit pair ports
  input wire logic wr16_en,
  input wire logic [3:0] wr16_pair,
  input wire logic [15:0] wr16_data,
  input wire logic [3:0] rd16_pair,
  output logic [15:0] rd16_data,
  // Bit copy and interrupt-enable instructions
  input wire logic bit_store_instr,
  input wire logic bit_load_instr,
  input wire logic [4:0] bit_reg_idx,
  input wire logic [2:0] bit_sel,
  input wire logic set_irq_enable_instr,
  input wire logic clear_irq_enable_instr,
  input wire logic return_from_irq_instr,
  // Pointers
  output logic [15:0] ptr_x,
  output logic [15:0] ptr_y,
  output logic [15:0] ptr_z,
  output logic [15:0] flash_lut_addr,
  // Data-space and direct I/O access
  input wire logic [15:0] ds_addr,
  input wire logic ds_read,
  input wire logic ds_write,
  input wire logic [7:0] ds_wdata,
  output logic [7:0] ds_rdata,
  input wire logic [5:0] io_addr,
  input wire logic io_read,
  input wire logic io_write,
  input wire logic [7:0] io_wdata,
  output logic [7:0] periph_addr,
  output logic periph_re,
  output logic periph_we,
  output logic [7:0] periph_wdata,
  input wire logic [7:0] periph_rdata,
  // Interrupts
  input wire logic [NUM_IRQ-1:0] irq_req,
  input wire logic instr_done,
  output logic irq_take,
  output logic [$clog2(NUM_IRQ)-1:0] irq_vector_idx,
  output logic [7:0] cpu_status_flags
);
  initial begin
    if (NUM_IRQ < 2 || NUM_IRQ > 64) $error("crf_core: NUM_IRQ out of range");
  end

  // Working registers, flags and pipeline state
  logic [7:0] regs_ff [crf_pkg::NUM_REGS];
  logic [7:0] flags_ff;
  logic [15:0] pc_ff;
  logic [15:0] exec_word_ff;
  logic [15:0] exec_ext_ff;
  logic exec_valid_ff;
  logic long_pend_ff;
  logic return_from_irq_instr_hold_ff; // One instruction runs after a return before next interrupt
  logic ack_ff;
  logic [31:0] rdata_ff;

  // Data-space decode
  logic ds_is_reg;
  logic ds_is_io;
  logic ds_is_ext;
  logic io_acc;
  logic [7:0] io_daddr;
  logic flags_sel;
  logic [7:0] b_opnd;
  logic [7:0] alu_res;
  logic a_c, a_h, a_v, a_n, a_z, a_s;
  logic arb_grant;
  logic avs_wr_hit;
  logic [7:0] nxt_flags;

  // Operand reads are combinational so the whole ALU step fits one cycle
  assign src_a_data = regs_ff[src_a_idx];
  assign src_b_data = regs_ff[src_b_idx];
  assign rd16_data = {regs_ff[{rd16_pair, 1'b1}], regs_ff[{rd16_pair, 1'b0}]};
  assign b_opnd = use_imm ? imm_data : src_b_data;

  // Pointer pairs, low byte in the even register
  assign ptr_x = {regs_ff[crf_pkg::PTR_X_LO + 5'h01], regs_ff[crf_pkg::PTR_X_LO]};
  assign ptr_y = {regs_ff[crf_pkg::PTR_Y_LO + 5'h01], regs_ff[crf_pkg::PTR_Y_LO]};
  assign ptr_z = {regs_ff[crf_pkg::PTR_Z_LO + 5'h01], regs_ff[crf_pkg::PTR_Z_LO]};
  assign flash_lut_addr = ptr_z;

  // ALU datapath
  crf_alu u_alu (
    .op_a(src_a_data),
    .op_b(b_opnd),
    .carry_in(flags_ff[crf_pkg::FLG_C]),
    .op(alu_op),
    .result(alu_res),
    .flag_c(a_c),
    .flag_h(a_h),
    .flag_v(a_v),
    .flag_n(a_n),
    .flag_z(a_z),
    .flag_s(a_s)
  );

  // Address decode: registers, then I/O window, then extended window
  always_comb begin
    ds_is_reg = (ds_addr < crf_pkg::DS_IO_BASE);
    ds_is_io = !ds_is_reg && (ds_addr < crf_pkg::DS_EXT_BASE);
    ds_is_ext = (ds_addr >= crf_pkg::DS_EXT_BASE) && (ds_addr <= crf_pkg::DS_EXT_END);
    // Direct I/O takes only six address bits, so it can never reach the extended window
    io_acc = io_read || io_write;
    io_daddr = io_acc ? ({2'b00, io_addr} + crf_pkg::DS_IO_BASE[7:0]) : ds_addr[7:0];
    flags_sel = io_acc ? (io_addr == crf_pkg::IO_FLAGS_ADDR)
                       : (ds_is_io && ds_addr[5:0] == crf_pkg::IO_FLAGS_ADDR);
  end

  // Peripheral strobes; the flags location is served internally
  assign periph_addr = io_daddr;
  assign periph_re = (io_read || (ds_read && (ds_is_io || ds_is_ext))) && !flags_sel;
  assign periph_we = (io_write || (ds_write && (ds_is_io || ds_is_ext))) && !flags_sel;
  assign periph_wdata = io_acc ? io_wdata : ds_wdata;

  // Read data for data-space and direct I/O loads
  always_comb begin
    if (flags_sel) begin
      ds_rdata = flags_ff;
    end else if (!io_acc && ds_is_reg) begin
      ds_rdata = regs_ff[ds_addr[4:0]];
    end else if (io_acc || ds_is_io || ds_is_ext) begin
      ds_rdata = periph_rdata;
    end else begin
      ds_rdata = 8'h00; // Above the extended window is outside this block
    end
  end

  // Register array write: one process per entry, highest priority first
  generate
    for (genvar g = 0; g < crf_pkg::NUM_REGS; g++) begin : g_reg
      localparam logic [4:0] IDX = 5'(g);
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          regs_ff[g] <= 8'h00;
        end else if (alu_en && dst_idx == IDX) begin
          regs_ff[g] <= alu_res;
        end else if (wr16_en && wr16_pair == IDX[4:1]) begin
          regs_ff[g] <= IDX[0] ? wr16_data[15:8] : wr16_data[7:0];
        end else if (bit_load_instr && bit_reg_idx == IDX) begin
          regs_ff[g][bit_sel] <= flags_ff[crf_pkg::FLG_T];
        end else if (ds_write && !io_acc && ds_is_reg && ds_addr[4:0] == IDX) begin
          regs_ff[g] <= ds_wdata;
        end
      end
    end
  endgenerate

  // Interrupt arbitration gated by the global enable
  crf_irq_arb #(
    .NUM_IRQ(NUM_IRQ)
  ) u_arb (
    .req(irq_req),
    .global_en(flags_ff[crf_pkg::FLG_I]),
    .grant(arb_grant),
    .grant_idx(irq_vector_idx)
  );

  // Take only at an instruction boundary, and never in the same cycle as a clear
  assign irq_take = arb_grant && instr_done && !return_from_irq_instr_hold_ff && !clear_irq_enable_instr;

  // Software write hit on the flags word
  assign avs_wr_hit = avs_write && ack_ff && avs_address == crf_pkg::OFS_FLAGS && avs_byteenable[0];

  // Next flags: stores first, then ALU result, bit copy, and interrupt enable last
  always_comb begin
    nxt_flags = flags_ff;
    if (avs_wr_hit) begin
      nxt_flags = avs_writedata[7:0];
    end
    if ((ds_write || io_write) && flags_sel) begin
      nxt_flags = periph_wdata;
    end
    if (alu_en) begin
      if (alu_flag_mask[crf_pkg::FLG_C]) nxt_flags[crf_pkg::FLG_C] = a_c;
      if (alu_flag_mask[crf_pkg::FLG_Z]) nxt_flags[crf_pkg::FLG_Z] = a_z;
      if (alu_flag_mask[crf_pkg::FLG_N]) nxt_flags[crf_pkg::FLG_N] = a_n;
      if (alu_flag_mask[crf_pkg::FLG_V]) nxt_flags[crf_pkg::FLG_V] = a_v;
      if (alu_flag_mask[crf_pkg::FLG_S]) nxt_flags[crf_pkg::FLG_S] = a_s;
      if (alu_flag_mask[crf_pkg::FLG_H]) nxt_flags[crf_pkg::FLG_H] = a_h;
    end
    if (bit_store_instr) begin
      nxt_flags[crf_pkg::FLG_T] = regs_ff[bit_reg_idx][bit_sel];
    end
    // Interrupt entry leaves every other flag untouched; software saves them
    if (irq_take) begin
      nxt_flags[crf_pkg::FLG_I] = 1'b0;
    end else if (set_irq_enable_instr || return_from_irq_instr) begin
      nxt_flags[crf_pkg::FLG_I] = 1'b1;
    end else if (clear_irq_enable_instr) begin
      nxt_flags[crf_pkg::FLG_I] = 1'b0;
    end
  end

  // Flags register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_ff <= crf_pkg::FLAGS_RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end
  assign cpu_status_flags = flags_ff;

  // Hold off interrupts for one instruction after a return
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      return_from_irq_instr_hold_ff <= 1'b0;
    end else if (return_from_irq_instr) begin
      return_from_irq_instr_hold_ff <= 1'b1;
    end else if (instr_done) begin
      return_from_irq_instr_hold_ff <= 1'b0;
    end
  end

  // Fetch stage: the next word is fetched while the current one executes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_ff <= crf_pkg::PC_RST;
    end else if (pc_load) begin
      pc_ff <= pc_load_val;
    end else begin
      pc_ff <= pc_ff + 16'h0001;
    end
  end
  assign prog_addr = pc_ff;

  // Execute register: a long instruction's second word lands in the extension
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      exec_word_ff <= 16'h0000;
      exec_ext_ff <= 16'h0000;
      exec_valid_ff <= 1'b0;
      long_pend_ff <= 1'b0;
    end else if (pc_load) begin
      // A jump flushes the prefetched word
      exec_valid_ff <= 1'b0;
      long_pend_ff <= 1'b0;
    end else if (exec_valid_ff && instr_long) begin
      exec_ext_ff <= prog_data;
      exec_valid_ff <= 1'b0;
      long_pend_ff <= 1'b1;
    end else begin
      exec_word_ff <= prog_data;
      exec_valid_ff <= 1'b1;
      long_pend_ff <= 1'b0;
    end
  end
  assign exec_word = exec_word_ff;
  assign exec_ext_word = exec_ext_ff;
  assign exec_valid = exec_valid_ff;

  // Avalon slave: one wait cycle, answer at the second edge
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read || avs_write) && !ack_ff;
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;

  // Read data captured in the wait cycle; unmapped offsets read zero
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read && !ack_ff) begin
      case (avs_address)
        crf_pkg::OFS_FLAGS: rdata_ff <= {24'h000000, flags_ff};
        crf_pkg::OFS_STATE: rdata_ff <= {pc_ff, 6'h00, return_from_irq_instr_hold_ff, exec_valid_ff, 8'h00};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_readdata = rdata_ff;

  // Checks
  a_irq_clears_i: assert property (@(posedge sys_clk) disable iff (!reset_n)
    irq_take |=> !flags_ff[crf_pkg::FLG_I]) else $error("I still set after irq");
  a_i_gates_irq: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !flags_ff[crf_pkg::FLG_I] |-> !irq_take) else $error("irq taken with I clear");
  a_sign_xor: assert property (@(posedge sys_clk) disable iff (!reset_n)
    alu_en && alu_flag_mask == 6'h3f |=> flags_ff[crf_pkg::FLG_S] ==
      (flags_ff[crf_pkg::FLG_N] ^ flags_ff[crf_pkg::FLG_V])) else $error("S not N xor V");
  a_alu_wb: assert property (@(posedge sys_clk) disable iff (!reset_n)
    alu_en |=> regs_ff[$past(dst_idx)] == $past(alu_res)) else $error("ALU result lost");
  a_zero_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
    alu_en && alu_flag_mask[crf_pkg::FLG_Z] |=> flags_ff[crf_pkg::FLG_Z] == ($past(alu_res) == 8'h00))
    else $error("Z wrong");
  a_neg_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
    alu_en && alu_flag_mask[crf_pkg::FLG_N] |=> flags_ff[crf_pkg::FLG_N] == $past(alu_res[7]))
    else $error("N wrong");
  a_sei_sets: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (set_irq_enable_instr || return_from_irq_instr) && !irq_take |=> flags_ff[crf_pkg::FLG_I])
    else $error("I not set");
  a_irq_prio: assert property (@(posedge sys_clk) disable iff (!reset_n)
    irq_take |-> irq_req[irq_vector_idx] && (irq_req & ((1 << irq_vector_idx) - 1)) == '0)
    else $error("lower vector not first");
  a_ds_reg_map: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ds_write && !io_acc && ds_addr < 16'h0020 && !alu_en && !wr16_en && !bit_load_instr
    |=> regs_ff[$past(ds_addr[4:0])] == $past(ds_wdata)) else $error("ds store missed reg");
  a_fetch_adv: assert property (@(posedge sys_clk) disable iff (!reset_n)
    reset_n && !pc_load |=> pc_ff == $past(pc_ff) + 16'h0001) else $error("PC did not advance");
  a_bus_wait: assert property (@(posedge sys_clk) disable iff (!reset_n)
    avs_read && avs_waitrequest |=> !avs_waitrequest) else $error("waitrequest too long");
  c_irq_taken: cover property (@(posedge sys_clk) disable iff (!reset_n) irq_take);
  c_long_instr: cover property (@(posedge sys_clk) disable iff (!reset_n) long_pend_ff);
  c_bit_copy: cover property (@(posedge sys_clk) disable iff (!reset_n) bit_store_instr ##1 bit_load_instr);
  c_ext_io: cover property (@(posedge sys_clk) disable iff (!reset_n) ds_write && ds_is_ext);
endmodule

// ### crf_pkg.sv
// Shared constants and types for the CPU register file and status flags
package crf_pkg;
  // Register file geometry
  localparam int NUM_REGS = 32;
  localparam int REG_W = 8;
  // Pointer pair low registers (26..31 form three 16-bit pointers)
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;
  // Data-space map
  localparam logic [15:0] DS_IO_BASE = 16'h0020;
  localparam logic [15:0] DS_EXT_BASE = 16'h0060;
  localparam logic [15:0] DS_EXT_END = 16'h00ff;
  localparam logic [5:0] IO_FLAGS_ADDR = 6'h3f;
  // Status flag bit positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  // Avalon byte offsets
  localparam logic [3:0] OFS_FLAGS = 4'h0;
  localparam logic [3:0] OFS_STATE = 4'h4;
  // Program counter reset value
  localparam logic [15:0] PC_RST = 16'h0000;
  // ALU operations
  typedef enum logic [2:0] {
    CRF_OP_ADD = 3'b000,
    CRF_OP_ADC = 3'b001,
    CRF_OP_SUB = 3'b010,
    CRF_OP_SBC = 3'b011,
    CRF_OP_AND = 3'b100,
    CRF_OP_OR = 3'b101,
    CRF_OP_EOR = 3'b110,
    CRF_OP_MOV = 3'b111
  } crf_alu_op_t;
endpackage

// ### crf_alu.sv
// Combinational 8-bit ALU with flag outputs
`timescale 1ns/1ps
module crf_alu (
  input wire logic [7:0] op_a,
  input wire logic [7:0] op_b,
  input wire logic carry_in,
  input wire crf_pkg::crf_alu_op_t op,
  output logic [7:0] result,
  output logic flag_c,
  output logic flag_h,
  output logic flag_v,
  output logic flag_n,
  output logic flag_z,
  output logic flag_s
);
  // Carry used by the chained forms only
  logic cin;
  logic [8:0] sum;
  logic [4:0] nib;

  // Arithmetic and logic in one pass; subtract borrows rather than carries
  always_comb begin
    cin = (op == crf_pkg::CRF_OP_ADC || op == crf_pkg::CRF_OP_SBC) ? carry_in : 1'b0;
    sum = 9'h000;
    nib = 5'h00;
    flag_c = 1'b0;
    flag_h = 1'b0;
    flag_v = 1'b0;
    case (op)
      crf_pkg::CRF_OP_ADD, crf_pkg::CRF_OP_ADC: begin
        sum = {1'b0, op_a} + {1'b0, op_b} + {8'h00, cin};
        nib = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, cin};
        flag_c = sum[8];
        flag_h = nib[4];
        flag_v = (op_a[7] == op_b[7]) && (sum[7] != op_a[7]);
      end
      crf_pkg::CRF_OP_SUB, crf_pkg::CRF_OP_SBC: begin
        sum = {1'b0, op_a} - {1'b0, op_b} - {8'h00, cin};
        nib = {1'b0, op_a[3:0]} - {1'b0, op_b[3:0]} - {4'h0, cin};
        flag_c = sum[8];
        flag_h = nib[4];
        flag_v = (op_a[7] != op_b[7]) && (sum[7] != op_a[7]);
      end
      crf_pkg::CRF_OP_AND: sum = {1'b0, op_a & op_b};
      crf_pkg::CRF_OP_OR: sum = {1'b0, op_a | op_b};
      crf_pkg::CRF_OP_EOR: sum = {1'b0, op_a ^ op_b};
      default: sum = {1'b0, op_b};
    endcase
    result = sum[7:0];
    flag_n = sum[7];
    flag_z = (sum[7:0] == 8'h00);
    flag_s = flag_n ^ flag_v;
  end
endmodule

// ### crf_irq_arb.sv
// Fixed-priority interrupt arbiter, lowest index wins
`timescale 1ns/1ps
module crf_irq_arb #(
  parameter int NUM_IRQ = 8
) (
  input wire logic [NUM_IRQ-1:0] req,
  input wire logic global_en,
  output logic grant,
  output logic [$clog2(NUM_IRQ)-1:0] grant_idx
);
  initial begin
    if (NUM_IRQ < 2 || NUM_IRQ > 64) $error("crf_irq_arb: NUM_IRQ out of range");
  end

  // Scan from the top so the lowest pending index is the last to land
  always_comb begin
    grant_idx = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (req[i]) begin
        grant_idx = i[$clog2(NUM_IRQ)-1:0];
      end
    end
    grant = global_en && (|req);
  end
endmodule

// ### crf_far_model.sv
// Far-side model: program memory and peripheral bus responder
`timescale 1ns/1ps
module crf_far_model (
  input wire logic sys_clk,
  input wire logic [15:0] prog_addr,
  output logic [15:0] prog_data,
  input wire logic [7:0] periph_addr,
  input wire logic periph_re,
  output logic [7:0] periph_rdata
);
  // Last value the peripheral bus carried
  logic [7:0] last_ff = 8'h00;
  // Program word depends on its address only, valid in the same cycle
  assign prog_data = {prog_addr[7:0] ^ 8'h3c, prog_addr[7:0]};
  // An unselected bus shows the inverse of the last value, so stale data never matches
  assign periph_rdata = periph_re ? (periph_addr ^ 8'h5a) : ~last_ff;
  // Remember what was last driven
  always_ff @(posedge sys_clk) begin
    if (periph_re) begin
      last_ff <= periph_addr ^ 8'h5a;
    end
  end
endmodule

// ### tb_cpu_register_file_status.sv
// Self-checking bench for the register file and status flags
`timescale 1ns/1ps
module tb_cpu_register_file_status;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, pc_load = 1'b0, instr_long = 1'b0;
  logic alu_en = 1'b0, use_imm = 1'b0, wr16_en = 1'b0, bit_store_instr = 1'b0, bit_load_instr = 1'b0;
  logic set_irq_enable_instr = 1'b0, clear_irq_enable_instr = 1'b0, return_from_irq_instr = 1'b0;
  logic ds_read = 1'b0, ds_write = 1'b0, io_read = 1'b0, io_write = 1'b0, instr_done = 1'b0;
  logic exec_valid, irq_take, periph_re, periph_we;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf, wr16_pair = 4'h0, rd16_pair = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd_word;
  logic [15:0] pc_load_val = 16'h0, wr16_data = 16'h0, ds_addr = 16'h0;
  logic [15:0] prog_addr, prog_data, exec_word, exec_ext_word, rd16_data, ptr_x, ptr_y, ptr_z, flash_lut_addr;
  crf_pkg::crf_alu_op_t alu_op = crf_pkg::CRF_OP_ADD;
  logic [4:0] src_a_idx = 5'h0, src_b_idx = 5'h0, dst_idx = 5'h0, bit_reg_idx = 5'h0;
  logic [7:0] imm_data = 8'h0, ds_wdata = 8'h0, io_wdata = 8'h0, irq_req = 8'h0;
  logic [7:0] src_a_data, src_b_data, ds_rdata, periph_addr, periph_wdata, periph_rdata, cpu_status_flags;
  logic [5:0] alu_flag_mask = 6'h0, io_addr = 6'h0;
  logic [2:0] bit_sel = 3'h0, irq_vector_idx;
  int fails = 0;
  int checked = 0;

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  crf_core i_crf_core (.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .prog_addr(prog_addr), .prog_data(prog_data),
    .pc_load(pc_load), .pc_load_val(pc_load_val), .exec_word(exec_word), .exec_ext_word(exec_ext_word),
    .exec_valid(exec_valid), .instr_long(instr_long), .alu_en(alu_en), .alu_op(alu_op), .src_a_idx(src_a_idx),
    .src_b_idx(src_b_idx), .use_imm(use_imm), .imm_data(imm_data), .dst_idx(dst_idx),
    .alu_flag_mask(alu_flag_mask), .src_a_data(src_a_data), .src_b_data(src_b_data), .wr16_en(wr16_en),
    .wr16_pair(wr16_pair), .wr16_data(wr16_data), .rd16_pair(rd16_pair), .rd16_data(rd16_data),
    .bit_store_instr(bit_store_instr), .bit_load_instr(bit_load_instr), .bit_reg_idx(bit_reg_idx),
    .bit_sel(bit_sel), .set_irq_enable_instr(set_irq_enable_instr), .clear_irq_enable_instr(clear_irq_enable_instr),
    .return_from_irq_instr(return_from_irq_instr), .ptr_x(ptr_x), .ptr_y(ptr_y), .ptr_z(ptr_z),
    .flash_lut_addr(flash_lut_addr), .ds_addr(ds_addr), .ds_read(ds_read), .ds_write(ds_write),
    .ds_wdata(ds_wdata), .ds_rdata(ds_rdata), .io_addr(io_addr), .io_read(io_read), .io_write(io_write),
    .io_wdata(io_wdata), .periph_addr(periph_addr), .periph_re(periph_re), .periph_we(periph_we),
    .periph_wdata(periph_wdata), .periph_rdata(periph_rdata), .irq_req(irq_req), .instr_done(instr_done),
    .irq_take(irq_take), .irq_vector_idx(irq_vector_idx), .cpu_status_flags(cpu_status_flags));

  crf_far_model i_crf_far_model (.sys_clk(sys_clk), .prog_addr(prog_addr), .prog_data(prog_data),
    .periph_addr(periph_addr), .periph_re(periph_re), .periph_rdata(periph_rdata));

  // Counted comparison; case inequality so unknowns fail
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One Avalon transfer, held until waitrequest is seen low at an edge
  task automatic av_xfer(input logic wr, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    avs_address <= adr;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Data-space read, judged once the combinational path settles
  task automatic ds_peek(input logic [15:0] adr, input logic [7:0] exp);
    @(posedge sys_clk);
    ds_read <= 1'b1;
    ds_addr <= adr;
    @(negedge sys_clk);
    chk(ds_rdata, exp, "data read");
    @(posedge sys_clk);
    ds_read <= 1'b0;
  endtask

  // Reset values, through the bus and at the port
  task automatic t_reset();
    av_xfer(1'b0, 4'h0, 32'h0, rd_word);
    chk(rd_word, 32'h0, "flags after reset");
    chk(cpu_status_flags, 8'h00, "flags port");
  endtask

  // Jump, then a plain fetch and a two-word instruction
  task automatic t_fetch();
    @(posedge sys_clk);
    pc_load <= 1'b1;
    pc_load_val <= 16'h0040;
    @(posedge sys_clk);
    pc_load <= 1'b0;
    @(posedge sys_clk);
    instr_long <= 1'b1;
    @(negedge sys_clk);
    chk(exec_word, 16'h7c40, "fetched word");
    chk(prog_addr, 16'h0041, "prefetch address");
    chk(exec_valid, 1'b1, "exec valid");
    @(posedge sys_clk);
    instr_long <= 1'b0;
    @(negedge sys_clk);
    chk(exec_ext_word, 16'h7d41, "second word");
  endtask

  // 16-bit writes to pairs, then pointers and 16-bit read
  task automatic t_pairs();
    for (int p = 13; p < 17; p++) begin
      @(posedge sys_clk);
      wr16_en <= 1'b1;
      wr16_pair <= p[3:0];
      wr16_data <= (p == 16) ? 16'h017f : {p[7:0], 8'hc0 | p[7:0]};
    end
    @(posedge sys_clk);
    wr16_en <= 1'b0;
    @(negedge sys_clk);
    chk(ptr_x, 16'h0dcd, "pointer x");
    chk(ptr_y, 16'h0ece, "pointer y");
    chk(ptr_z, 16'h0fcf, "pointer z");
    chk(flash_lut_addr, 16'h0fcf, "table address");
    chk(rd16_data, 16'h017f, "pair read");
  endtask

  // Back-to-back ALU ops: add overflow, subtract borrow, masked logic zero
  task automatic t_alu();
    @(posedge sys_clk);
    alu_en <= 1'b1;
    alu_flag_mask <= 6'h3f;
    src_b_idx <= 5'h01;
    dst_idx <= 5'h02;
    @(posedge sys_clk);
    alu_op <= crf_pkg::CRF_OP_SUB;
    src_a_idx <= 5'h04;
    use_imm <= 1'b1;
    imm_data <= 8'h01;
    dst_idx <= 5'h03;
    @(negedge sys_clk);
    chk(cpu_status_flags, 8'h2c, "add flags");
    @(posedge sys_clk);
    alu_op <= crf_pkg::CRF_OP_AND;
    src_a_idx <= 5'h00;
    src_b_idx <= 5'h02;
    use_imm <= 1'b0;
    dst_idx <= 5'h05;
    alu_flag_mask <= 6'h1e;
    @(negedge sys_clk);
    chk(cpu_status_flags, 8'h35, "sub flags");
    @(posedge sys_clk);
    alu_en <= 1'b0;
    @(negedge sys_clk);
    chk(cpu_status_flags, 8'h23, "and flags");
    ds_peek(16'h0002, 8'h80);
    ds_peek(16'h0003, 8'hff);
    ds_peek(16'h0005, 8'h00);
  endtask

  // Store into register space, direct I/O read, extended I/O read, flags store over I/O
  task automatic t_data();
    @(posedge sys_clk);
    ds_write <= 1'b1;
    ds_addr <= 16'h001a;
    ds_wdata <= 8'h77;
    @(posedge sys_clk);
    ds_write <= 1'b0;
    io_read <= 1'b1;
    io_addr <= 6'h05;
    @(negedge sys_clk);
    chk(ptr_x, 16'h0d77, "store to register");
    chk({periph_re, periph_addr, ds_rdata}, {1'b1, 8'h25, 8'h7f}, "direct io read");
    @(posedge sys_clk);
    io_read <= 1'b0;
    ds_peek(16'h0065, 8'h3f);
    @(posedge sys_clk);
    io_write <= 1'b1;
    io_addr <= 6'h3f;
    @(negedge sys_clk);
    chk({periph_we, periph_wdata}, 9'h000, "io flags store off bus");
    @(posedge sys_clk);
    io_write <= 1'b0;
    @(negedge sys_clk);
    chk(cpu_status_flags, 8'h00, "flags via io");
  endtask

  // Copy bit 7 of r2 into the copy bit, then into bit 0 of r5
  task automatic t_bits();
    @(posedge sys_clk);
    bit_store_instr <= 1'b1;
    bit_reg_idx <= 5'h02;
    bit_sel <= 3'h7;
    @(posedge sys_clk);
    bit_store_instr <= 1'b0;
    bit_load_instr <= 1'b1;
    bit_reg_idx <= 5'h05;
    bit_sel <= 3'h0;
    @(posedge sys_clk);
    bit_load_instr <= 1'b0;
    @(negedge sys_clk);
    chk(cpu_status_flags, 8'h40, "copy bit");
    ds_peek(16'h0005, 8'h01);
  endtask

  // Global enable gating, priority, clear on take, set on return, clear instruction
  task automatic t_irq();
    @(posedge sys_clk);
    irq_req <= 8'h0c;
    instr_done <= 1'b1;
    set_irq_enable_instr <= 1'b1;
    @(negedge sys_clk);
    chk(irq_take, 1'b0, "blocked while disabled");
    @(posedge sys_clk);
    set_irq_enable_instr <= 1'b0;
    @(negedge sys_clk);
    chk({irq_take, irq_vector_idx}, {1'b1, 3'h2}, "take lowest");
    @(posedge sys_clk);
    irq_req <= 8'h00;
    instr_done <= 1'b0;
    return_from_irq_instr <= 1'b1;
    @(negedge sys_clk);
    chk(cpu_status_flags, 8'h40, "enable cleared on take");
    @(posedge sys_clk);
    return_from_irq_instr <= 1'b0;
    irq_req <= 8'h01;
    instr_done <= 1'b1;
    clear_irq_enable_instr <= 1'b1;
    @(negedge sys_clk);
    chk({irq_take, cpu_status_flags}, {1'b0, 8'hc0}, "return sets, clear blocks");
    @(posedge sys_clk);
    clear_irq_enable_instr <= 1'b0;
    irq_req <= 8'h00;
    instr_done <= 1'b0;
  endtask

  // Register bus write and read back, plus an unmapped offset
  task automatic t_bus();
    av_xfer(1'b1, 4'h0, 32'h0000_0083, rd_word);
    av_xfer(1'b0, 4'h0, 32'h0, rd_word);
    chk(rd_word, 32'h0000_0083, "flags read back");
    av_xfer(1'b1, 4'h8, 32'h0000_00ff, rd_word);
    av_xfer(1'b0, 4'h8, 32'h0, rd_word);
    chk(rd_word, 32'h0, "unmapped offset");
  endtask

  // Counts, verdict and end of run
  task automatic final_report();
    $display("checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    t_fetch();
    t_pairs();
    t_alu();
    t_data();
    t_bits();
    t_irq();
    t_bus();
    final_report();
  end

  // Watchdog: the tests need under a hundred cycles
  initial begin
    #10000;
    fails++;
    final_report();
  end
endmodule
